// ### hw/rssp_pkg.sv
package rssp_pkg;
  localparam logic [7:0] RSSP_SLAVE_ADDR = 8'hd0;
  localparam int         RSSP_NUM_REGS   = 8;
  localparam int         RSSP_PTR_W      = 3;
  localparam int         RSSP_WR_W       = RSSP_PTR_W + 8;
  localparam int         RSSP_FIFO_DEPTH = 16;
  localparam logic [3:0] RSSP_BYTE_BITS  = 4'h8;
  localparam logic [3:0] RSSP_CNT_RST    = 4'h0;
  localparam logic [3:0] RSSP_CNT_FIRST  = 4'h1;
  localparam logic [2:0] RSSP_PTR_RST    = 3'h0;
  localparam logic [7:0] RSSP_REG_RST    = 8'h00;

  typedef enum logic [2:0] {
    RSSP_IDLE,
    RSSP_ADDR,
    RSSP_ACK_ADDR,
    RSSP_WR_BYTE,
    RSSP_WR_HOLD,
    RSSP_ACK_WR,
    RSSP_RD_BYTE,
    RSSP_RD_ACK
  } rssp_state_t;
endpackage

// ### hw/rssp_strm_if.sv
`timescale 1ns/10ps
interface rssp_strm_if #(
  parameter int W = 11
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### hw/rssp_fifo.sv
`timescale 1ns/10ps
module rssp_fifo import rssp_pkg::*; #(
  parameter int W = RSSP_WR_W,
  parameter int D = RSSP_FIFO_DEPTH
) (
  input wire logic  ref_clk,
  input wire logic  nrst,
  rssp_strm_if.snk  in_s,
  rssp_strm_if.src  out_s
);
  localparam int          AW       = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
    logic                vld;
    logic                rdy;
  } rssp_fifo_st_t;

  rssp_fifo_st_t st_q;
  rssp_fifo_st_t st_d;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    st_d = st_q;
    push = in_s.valid && st_q.rdy;
    pop  = st_q.vld && out_s.ready;
    if (push) begin
      st_d.mem[st_q.wr] = in_s.data;
      st_d.wr           = nxt(st_q.wr);
    end
    if (pop) begin
      st_d.rd = nxt(st_q.rd);
    end
    st_d.cnt = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    st_d.vld = (st_d.cnt != '0);
    st_d.rdy = (st_d.cnt != FULL_CNT);
  end

  assign in_s.ready  = st_q.rdy;
  assign out_s.valid = st_q.vld;
  assign out_s.data  = st_q.mem[st_q.rd];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q     <= '0;
      st_q.rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ### hw/rssp_top.sv
`timescale 1ns/10ps
module rssp_top import rssp_pkg::*; #(
  parameter int FIFO_DEPTH = RSSP_FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  scl_in,
  output wire logic                  scl_out,
  output wire logic                  scl_oe,
  input  wire logic                  sda_in,
  output wire logic                  sda_out,
  output wire logic                  sda_oe,
  output wire logic                  busy,
  input  wire logic                  upd_valid,
  input  wire logic [RSSP_PTR_W-1:0] upd_addr,
  input  wire logic [7:0]            upd_data,
  output wire logic                  wr_valid,
  input  wire logic                  wr_ready,
  output wire logic [RSSP_PTR_W-1:0] wr_addr,
  output wire logic [7:0]            wr_data
);
  typedef struct packed {
    rssp_state_t                   state;
    logic [3:0]                    cnt;
    logic [7:0]                    shift;
    logic                          rw;
    logic                          first;
    logic                          acked;
    logic [RSSP_PTR_W-1:0]         ptr;
    logic                          sda_oe;
    logic                          scl_oe;
    logic                          busy;
    logic                          pin_lvl;
    logic                          scl_s1;
    logic                          scl_s2;
    logic                          scl_d;
    logic                          sda_s1;
    logic                          sda_s2;
    logic                          sda_d;
    logic [RSSP_NUM_REGS-1:0][7:0] img;
  } rssp_core_st_t;

  rssp_core_st_t st_q;
  rssp_core_st_t st_d;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_cond;
  logic          stop_cond;
  logic          addr_hit;
  logic          push_valid;

  rssp_strm_if #(.W(RSSP_WR_W)) wr_if ();
  rssp_strm_if #(.W(RSSP_WR_W)) core_if ();

  // Pointer is three bits wide, so control rolls over to seconds
  function automatic logic [RSSP_PTR_W-1:0] ptr_next(input logic [RSSP_PTR_W-1:0] p);
    return p + 1'b1;
  endfunction

  // Edges seen only after the two-flop synchronisers
  assign scl_rise   = st_q.scl_s2 && !st_q.scl_d;
  assign scl_fall   = !st_q.scl_s2 && st_q.scl_d;
  assign start_cond = st_q.scl_s2 && st_q.scl_d && st_q.sda_d && !st_q.sda_s2;
  assign stop_cond  = st_q.scl_s2 && st_q.scl_d && !st_q.sda_d && st_q.sda_s2;
  assign addr_hit   = (st_q.shift[7:1] == RSSP_SLAVE_ADDR[7:1]);

  always_comb begin
    st_d        = st_q;
    push_valid  = 1'b0;
    st_d.scl_s1 = scl_in;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_d  = st_q.scl_s2;
    st_d.sda_s1 = sda_in;
    st_d.sda_s2 = st_q.sda_s1;
    st_d.sda_d  = st_q.sda_s2;
    // Core writes BCD time into the image; bytes are passed as given
    if (upd_valid) begin
      st_d.img[upd_addr] = upd_data;
    end
    // Bus conditions override any byte in flight, repeated START included
    if (start_cond) begin
      st_d.state  = RSSP_ADDR;
      st_d.cnt    = RSSP_CNT_RST;
      st_d.sda_oe = 1'b0;
      st_d.scl_oe = 1'b0;
      st_d.busy   = 1'b1;
    end else if (stop_cond) begin
      st_d.state  = RSSP_IDLE;
      st_d.sda_oe = 1'b0;
      st_d.scl_oe = 1'b0;
      st_d.busy   = 1'b0;
    end else begin
      case (st_q.state)
        RSSP_IDLE: begin
          st_d.sda_oe = 1'b0;
        end
        RSSP_ADDR: begin
          if (scl_rise && st_q.cnt != RSSP_BYTE_BITS) begin
            st_d.shift = {st_q.shift[6:0], st_q.sda_s2};
            st_d.cnt   = st_q.cnt + 1'b1;
          end else if (scl_fall && st_q.cnt == RSSP_BYTE_BITS) begin
            st_d.rw = st_q.shift[0];
            if (addr_hit) begin
              st_d.sda_oe = 1'b1;
              st_d.state  = RSSP_ACK_ADDR;
            end else begin
              st_d.sda_oe = 1'b0;
              st_d.state  = RSSP_IDLE;
              st_d.busy   = 1'b0;
            end
          end
        end
        RSSP_ACK_ADDR: begin
          if (scl_fall) begin
            if (st_q.rw) begin
              // Read starts wherever the pointer was left
              st_d.shift  = {st_q.img[st_q.ptr][6:0], 1'b0};
              st_d.sda_oe = !st_q.img[st_q.ptr][7];
              st_d.cnt    = RSSP_CNT_FIRST;
              st_d.state  = RSSP_RD_BYTE;
            end else begin
              st_d.sda_oe = 1'b0;
              st_d.first  = 1'b1;
              st_d.cnt    = RSSP_CNT_RST;
              st_d.state  = RSSP_WR_BYTE;
            end
          end
        end
        RSSP_WR_BYTE: begin
          if (scl_rise && st_q.cnt != RSSP_BYTE_BITS) begin
            st_d.shift = {st_q.shift[6:0], st_q.sda_s2};
            st_d.cnt   = st_q.cnt + 1'b1;
          end else if (scl_fall && st_q.cnt == RSSP_BYTE_BITS) begin
            st_d.sda_oe = 1'b1;
            if (st_q.first) begin
              st_d.ptr   = st_q.shift[RSSP_PTR_W-1:0];
              st_d.first = 1'b0;
              st_d.state = RSSP_ACK_WR;
            end else if (wr_if.ready) begin
              push_valid = 1'b1;
              st_d.ptr   = ptr_next(st_q.ptr);
              st_d.state = RSSP_ACK_WR;
            end else begin
              // Buffer full: stretch the clock low rather than drop a byte
              st_d.scl_oe = 1'b1;
              st_d.state  = RSSP_WR_HOLD;
            end
          end
        end
        RSSP_WR_HOLD: begin
          if (wr_if.ready) begin
            push_valid  = 1'b1;
            st_d.ptr    = ptr_next(st_q.ptr);
            st_d.scl_oe = 1'b0;
            st_d.state  = RSSP_ACK_WR;
          end
        end
        RSSP_ACK_WR: begin
          // Ack held until the ninth clock falls again
          if (scl_fall) begin
            st_d.sda_oe = 1'b0;
            st_d.cnt    = RSSP_CNT_RST;
            st_d.state  = RSSP_WR_BYTE;
          end
        end
        RSSP_RD_BYTE: begin
          if (scl_fall) begin
            if (st_q.cnt == RSSP_BYTE_BITS) begin
              st_d.sda_oe = 1'b0;
              st_d.state  = RSSP_RD_ACK;
            end else begin
              st_d.sda_oe = !st_q.shift[7];
              st_d.shift  = {st_q.shift[6:0], 1'b0};
              st_d.cnt    = st_q.cnt + 1'b1;
            end
          end
        end
        RSSP_RD_ACK: begin
          if (scl_rise) begin
            st_d.acked = !st_q.sda_s2;
            if (!st_q.sda_s2) begin
              st_d.ptr = ptr_next(st_q.ptr);
            end
          end else if (scl_fall) begin
            if (st_q.acked) begin
              st_d.shift  = {st_q.img[st_q.ptr][6:0], 1'b0};
              st_d.sda_oe = !st_q.img[st_q.ptr][7];
              st_d.cnt    = RSSP_CNT_FIRST;
              st_d.state  = RSSP_RD_BYTE;
            end else begin
              // Line stays released so the master can issue STOP
              st_d.sda_oe = 1'b0;
              st_d.state  = RSSP_IDLE;
            end
          end
        end
        default: begin
          st_d.state = RSSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q        <= '0;
      st_q.state  <= RSSP_IDLE;
      st_q.ptr    <= RSSP_PTR_RST;
      st_q.cnt    <= RSSP_CNT_RST;
      st_q.shift  <= RSSP_REG_RST;
      st_q.scl_s1 <= 1'b1;
      st_q.scl_s2 <= 1'b1;
      st_q.scl_d  <= 1'b1;
      st_q.sda_s1 <= 1'b1;
      st_q.sda_s2 <= 1'b1;
      st_q.sda_d  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wr_if.valid   = push_valid;
  assign wr_if.data    = {st_q.ptr, st_q.shift};
  assign core_if.ready = wr_ready;

  rssp_fifo #(
    .W (RSSP_WR_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .in_s    (wr_if),
    .out_s   (core_if)
  );

  assign scl_out = st_q.pin_lvl;
  assign scl_oe  = st_q.scl_oe;
  assign sda_out = st_q.pin_lvl;
  assign sda_oe  = st_q.sda_oe;
  assign busy    = st_q.busy;
  assign wr_valid = core_if.valid;
  assign wr_addr  = core_if.data[RSSP_WR_W-1:8];
  assign wr_data  = core_if.data[7:0];

  property p_addr_ack;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_ADDR && scl_fall && st_q.cnt == RSSP_BYTE_BITS && addr_hit
     && !start_cond && !stop_cond)
    |=> (st_q.sda_oe && st_q.state == RSSP_ACK_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_addr_foreign;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_ADDR && scl_fall && st_q.cnt == RSSP_BYTE_BITS && !addr_hit
     && !start_cond && !stop_cond)
    |=> (!st_q.sda_oe && st_q.state == RSSP_IDLE);
  endproperty
  a_addr_foreign: assert property (p_addr_foreign)
    else $error("foreign address acknowledged");

  property p_start;
    @(posedge ref_clk) disable iff (!nrst)
    start_cond |=> (st_q.state == RSSP_ADDR && st_q.cnt == RSSP_CNT_RST && !st_q.sda_oe);
  endproperty
  a_start: assert property (p_start) else $error("START not taken");

  property p_stop;
    @(posedge ref_clk) disable iff (!nrst)
    (stop_cond && !start_cond) |=> (st_q.state == RSSP_IDLE && !st_q.sda_oe && !st_q.scl_oe);
  endproperty
  a_stop: assert property (p_stop) else $error("STOP did not end transfer");

  property p_ptr_load;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_WR_BYTE && st_q.first && scl_fall && st_q.cnt == RSSP_BYTE_BITS
     && !start_cond && !stop_cond)
    |=> (st_q.ptr == $past(st_q.shift[RSSP_PTR_W-1:0]) && st_q.sda_oe);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not loaded");

  property p_rd_ack_inc;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_RD_ACK && scl_rise && !st_q.sda_s2 && !stop_cond)
    |=> (st_q.ptr == ptr_next($past(st_q.ptr)));
  endproperty
  a_rd_ack_inc: assert property (p_rd_ack_inc)
    else $error("pointer missed increment");

  property p_rd_nack_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_RD_ACK && scl_rise && st_q.sda_s2 && !upd_valid)
    |=> (st_q.ptr == $past(st_q.ptr)) ##1 (st_q.ptr == $past(st_q.ptr, 2));
  endproperty
  a_rd_nack_hold: assert property (p_rd_nack_hold)
    else $error("pointer moved on no ack");

  property p_nack_release;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_RD_ACK && !st_q.acked && scl_fall && !start_cond)
    |=> (!st_q.sda_oe && st_q.state == RSSP_IDLE);
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data line kept after nack");

  property p_sda_edge_low;
    @(posedge ref_clk) disable iff (!nrst)
    ($changed(st_q.sda_oe) && !$past(stop_cond) && !$past(start_cond)
     && $past(st_q.state) != RSSP_WR_HOLD)
    |-> !$past(st_q.scl_s2);
  endproperty
  a_sda_edge_low: assert property (p_sda_edge_low)
    else $error("data moved while clock high");

  property p_ack_stable;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_ACK_WR && scl_rise) |-> st_q.sda_oe ##1 st_q.sda_oe;
  endproperty
  a_ack_stable: assert property (p_ack_stable)
    else $error("ack dropped during clock high");

  property p_data_ack;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_WR_BYTE && !st_q.first && scl_fall && st_q.cnt == RSSP_BYTE_BITS
     && !start_cond && !stop_cond)
    |=> st_q.sda_oe && ($past(wr_if.ready)
      ? (st_q.ptr == ptr_next($past(st_q.ptr)) && st_q.state == RSSP_ACK_WR)
      : (st_q.scl_oe && st_q.state == RSSP_WR_HOLD));
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");

  property p_stretch_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_WR_HOLD && !wr_if.ready && !start_cond && !stop_cond)
    |=> (st_q.scl_oe && st_q.sda_oe && st_q.state == RSSP_WR_HOLD);
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("stretch dropped");

  property p_ptr_wrap;
    @(posedge ref_clk) disable iff (!nrst)
    (st_q.state == RSSP_RD_ACK && scl_rise && !st_q.sda_s2 && st_q.ptr == '1 && !stop_cond)
    |=> (st_q.ptr == RSSP_PTR_RST);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  c_read_acked: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_q.state == RSSP_RD_ACK && scl_fall && st_q.acked);
  c_write_byte: cover property (@(posedge ref_clk) disable iff (!nrst) push_valid);
  c_stretch: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_q.state == RSSP_WR_HOLD);
  c_foreign: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_q.state == RSSP_ADDR && scl_fall && st_q.cnt == RSSP_BYTE_BITS && !addr_hit);
endmodule

// ### testbench/rssp_bus_master.sv
`timescale 1ns/10ps
module rssp_bus_master #(
  parameter int HOLD_CYC = 120,
  parameter int FREE_CYC = 260
) (
  input  wire logic ref_clk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_pull,
  output logic      sda_pull,
  output logic      hang
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    hang     = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One bit, entered and left with the clock just pulled low
  task automatic bit_io(input logic b, output logic r);
    int n;
    tick(6);
    sda_pull <= !b;
    tick(7);
    scl_pull <= 1'b0;
    n = 0;
    // Slave may stretch; bounded so a stuck clock ends the run
    while (scl_line !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      hang <= 1'b1;
    end
    tick(6);
    r = sda_line;
    tick(6);
    scl_pull <= 1'b1;
  endtask

  // Data falls with clock high, from idle or as a repeat
  task automatic start();
    tick(6);
    sda_pull <= 1'b0;
    tick(7);
    scl_pull <= 1'b0;
    tick(HOLD_CYC);
    sda_pull <= 1'b1;
    tick(HOLD_CYC); // First clock 600 ns on
    scl_pull <= 1'b1;
  endtask

  // Data rises with clock high, then the bus stays free
  task automatic stop();
    tick(6);
    sda_pull <= 1'b1;
    tick(7);
    scl_pull <= 1'b0;
    tick(HOLD_CYC);
    sda_pull <= 1'b0;
    tick(FREE_CYC);
  endtask

  // Eight bits MSB first, then the ninth clock for the answer
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Acknowledge all wanted bytes but the last
  task automatic get_byte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ### testbench/rtc_serial_slave_port_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module rtc_serial_slave_port_test import rssp_pkg::*; ();
  logic                  ref_clk;
  logic                  nrst;
  logic                  scl_oe;
  logic                  sda_oe;
  logic                  busy;
  logic                  upd_valid;
  logic [RSSP_PTR_W-1:0] upd_addr;
  logic [7:0]            upd_data;
  logic                  wr_valid;
  logic                  wr_ready;
  logic [RSSP_PTR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  m_scl;
  logic                  m_sda;
  logic                  m_hang;
  logic                  scl_lvl;
  logic                  sda_lvl;
  logic                  stretched;
  logic [10:0]           exp_w;
  time                   stall_end;
  wire logic             scl_w;
  wire logic             sda_w;
  logic [7:0]            img [8];
  logic [2:0]            ptr;
  logic [10:0]           exp_q [$];
  int                    bad_count;
  int                    compares;

  // Both lines pulled up; any party pulls low
  assign scl_w = !(m_scl | scl_oe);
  assign sda_w = !(m_sda | sda_oe);

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // Small FIFO so a long core stall forces clock stretching
  rssp_top #(.FIFO_DEPTH(2)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_w), .scl_out(scl_lvl), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_lvl), .sda_oe(sda_oe), .busy(busy), .upd_valid(upd_valid),
    .upd_addr(upd_addr), .upd_data(upd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data)
  );

  rssp_bus_master master_u (
    .ref_clk(ref_clk), .scl_line(scl_w), .sda_line(sda_w),
    .scl_pull(m_scl), .sda_pull(m_sda), .hang(m_hang)
  );

  function automatic logic [7:0] bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    // Core may be held off for a while so the buffer fills
    wr_ready <= ($time > stall_end) && ($urandom_range(3) == 0);
    if (scl_oe === 1'b1) begin
      stretched <= 1'b1;
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        exp_w = exp_q.pop_front();
        `CHK({wr_addr, wr_data}, exp_w)
      end
    end
    if (m_hang === 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic load_image();
    for (int i = 0; i < 8; i++) begin
      img[i] = bcd($urandom_range(99));
      upd_valid <= 1'b1;
      upd_addr  <= 3'(i);
      upd_data  <= img[i];
      @(posedge ref_clk);
    end
    upd_valid <= 1'b0;
  endtask

  // Leaves the bus held, so a read after it is a repeated start
  task automatic do_write(input logic [7:0] p, input int k);
    logic       ack;
    logic [7:0] d;
    master_u.start();
    master_u.put_byte(RSSP_SLAVE_ADDR, ack);
    `CHK(ack, 1'b1)
    master_u.put_byte(p, ack);
    `CHK(ack, 1'b1)
    ptr = p[2:0];
    for (int i = 0; i < k; i++) begin
      d = 8'($urandom);
      exp_q.push_back({ptr, d});
      ptr++;
      master_u.put_byte(d, ack);
      `CHK(ack, 1'b1)
    end
  endtask

  task automatic do_read(input int k);
    logic       ack;
    logic [7:0] v;
    master_u.start();
    master_u.put_byte(RSSP_SLAVE_ADDR | 8'h01, ack);
    `CHK(ack, 1'b1)
    `CHK(busy, 1'b1)
    for (int i = 0; i < k; i++) begin
      master_u.get_byte(i < k - 1, v);
      `CHK(v, img[ptr])
      if (i < k - 1) begin
        ptr++;
      end
    end
    master_u.tick(6);
    `CHK(sda_oe, 1'b0)
    master_u.stop();
    `CHK(busy, 1'b0)
  endtask

  initial begin
    logic [7:0] a;
    int         n;
    nrst      = 1'b0;
    upd_valid = 1'b0;
    upd_addr  = 3'h0;
    upd_data  = 8'h00;
    wr_ready  = 1'b0;
    bad_count = 0;
    compares  = 0;
    ptr       = 3'h0;
    stretched = 1'b0;
    stall_end = 0;
    void'($urandom(4));
    repeat (12) @(posedge ref_clk);
    `CHK({sda_oe, scl_oe, busy, wr_valid}, 4'h0)
    nrst <= 1'b1;
    master_u.tick(4);
    load_image();
    do_read(9); // From the retained pointer, wrapping
    do_read(1); // Nack keeps the pointer
    do_read(2);
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      if (a[7:1] == 7'h68) begin
        a = a ^ 8'h80;
      end
      master_u.start();
      master_u.put_byte(a, a[0]);
      `CHK(a[0], 1'b0)
      master_u.tick(6);
      `CHK(busy, 1'b0)
      master_u.stop();
    end
    // Core stalled past the third data byte, so the clock must be stretched
    stall_end = $time + 7500;
    do_write(8'hf5, 5); // Upper pointer bits ignored, wraps
    master_u.stop();
    `CHK(stretched, 1'b1)
    do_read(3);
    for (int i = 0; i < 8; i++) begin
      if ($urandom_range(1) == 1) begin
        load_image();
      end
      do_write(8'($urandom), $urandom_range(6, 1));
      if ($urandom_range(1) == 1) begin
        master_u.stop();
      end
      do_read($urandom_range(9, 1));
    end
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(exp_q.size(), 0)
    `CHK({scl_lvl, sda_lvl}, 2'h0)
    tally_and_finish();
  end
endmodule
